/* pmbcs_pkg.sv */
// shared constants of the management-bus command block
package pmbcs_pkg;
  // interpreter states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000, // bus free or not addressed
    S_RX    = 3'b001, // shifting a byte in
    S_RXACK = 3'b010, // driving or waiting out an ack slot
    S_TX    = 3'b011, // shifting a byte out
    S_TXACK = 3'b100  // sampling the host ack
  } pmbcs_st_t;
  // command codes
  localparam logic [7:0] CMD_OPER  = 8'h01;
  localparam logic [7:0] CMD_ONOFF = 8'h02;
  localparam logic [7:0] CMD_STORE = 8'h11;
  localparam logic [7:0] CMD_VOUT  = 8'h21;
  localparam logic [7:0] CMD_MHI   = 8'h25;
  localparam logic [7:0] CMD_MLO   = 8'h26;
  localparam logic [7:0] CMD_VINON = 8'h35;
  localparam logic [7:0] CMD_VINOF = 8'h36;
  localparam logic [7:0] CMD_TDLY  = 8'h60;
  localparam logic [7:0] CMD_TRISE = 8'h61;
  localparam logic [7:0] CMD_RVIN  = 8'h88;
  localparam logic [7:0] CMD_RVOUT = 8'h8b;
  localparam logic [7:0] CMD_RIOUT = 8'h8c;
  localparam logic [7:0] CMD_WP    = 8'hd0;
  localparam logic [7:0] CMD_VOTRM = 8'hd4;
  localparam logic [7:0] CMD_VITRM = 8'hd5;
  localparam logic [7:0] CMD_VIGN  = 8'hd6;
  // fixed exponents of the linear words
  localparam logic [4:0] EXP_M3 = 5'h1d;
  localparam logic [4:0] EXP_M1 = 5'h1f;
  // accepted ranges, mantissa units
  localparam logic [10:0] VIN_MIN = 11'h100; // 32 V
  localparam logic [10:0] VIN_MAX = 11'h170; // 46 V
  localparam logic [10:0] TDLY_MIN = 11'h014; // 10 ms
  localparam logic [10:0] TRISE_MIN = 11'h01e; // 15 ms
  localparam logic [10:0] TON_MAX = 11'h3e8; // 500 ms
  localparam logic [15:0] VOUT_MIN = 16'h819a; // 8.10 V rounded up
  localparam logic [15:0] VOUT_MAX = 16'hd333; // 13.20 V rounded down
  localparam logic [10:0] IOUT_BLANK = 11'h00e; // first unblanked step above 1.65 A
  // bit positions
  localparam int OP_ON = 7;
  localparam int CFG_CMD = 3;
  // reset values
  localparam logic [7:0] OP_RST = 8'h08;
  localparam logic [7:0] CFG_RST = 8'h1f;
  localparam logic [15:0] VINON_RST = 16'he910;
  localparam logic [15:0] VINOF_RST = 16'he900;
  localparam logic [15:0] TDLY_RST = 16'hf814;
  localparam logic [15:0] TRISE_RST = 16'hf81e;
  localparam logic [15:0] VOUT_RST = 16'hc000;
  localparam logic [15:0] MHI_RST = 16'hc99a;
  localparam logic [15:0] MLO_RST = 16'hb666;
  localparam logic [15:0] VOTRM_RST = 16'h0000;
  localparam logic [15:0] VITRM_RST = 16'he800;
  localparam logic [15:0] VIGN_RST = 16'h2000;
  localparam logic [6:0] ADDR_RST = 7'h10;
endpackage

/* pmbcs_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pmbcs_top #(
  parameter logic [6:0] BUS_ADDR = pmbcs_pkg::ADDR_RST // bus address
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic rst_b_i, // async reset, low
  input wire logic scl_i, // bus clock pin
  input wire logic sda_i, // bus data pin level
  output logic sda_o, // bus data drive value
  output logic sda_oe_o, // bus data pulled low
  input wire logic on_off_pin_i, // analog on/off pin
  input wire logic [15:0] vout_adc_i, // raw output voltage
  input wire logic [10:0] vin_adc_i, // raw input voltage
  input wire logic [10:0] iout_adc_i, // raw output current
  output logic out_en_o, // converter output enable
  output logic [15:0] vout_target_o, // active set-point
  output logic [15:0] turn_on_delay_time_o, // turn-on delay word
  output logic [15:0] turn_on_rise_time_o, // rise time word
  output logic [15:0] vin_on_o, // turn-on threshold word
  output logic [15:0] vin_off_o, // turn-off threshold word
  output logic store_o // save-to-storage strobe
);
  // whole state of the block
  typedef struct packed {
    logic scl1, scl2, scl3; // clock pin sync and history
    logic sda1, sda2, sda3; // data pin sync and history
    logic pin1, pin2; // on/off pin sync
    pmbcs_pkg::pmbcs_st_t st; // bus state
    logic adr; // next byte is an address
    logic rd; // read direction
    logic [3:0] bcnt; // bit counter
    logic [7:0] sh; // shift register
    logic [2:0] nb; // bytes after address
    logic [1:0] txi; // bytes sent
    logic [7:0] cmd, d0, d1; // received bytes
    logic [7:0] crc; // running error check
    logic oe; // data pin drive
    logic wp; // write protection
    logic [7:0] op; // operation byte
    logic [7:0] cfg; // on/off options
    logic [15:0] vin_on, vin_off, tdly, trise; // linear words
    logic [15:0] vout, mhi, mlo; // output voltage words
    logic out_en; // output enable
    logic [15:0] vtgt; // active set-point
    logic store; // store strobe
  } pmbcs_s_t;

  pmbcs_s_t s_r; // registered state
  pmbcs_s_t s_nxt; // next state

  // error check update, polynomial x8+x2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // data bytes a command carries, 3 means unsupported
  function automatic logic [1:0] cmd_len(input logic [7:0] c);
    case (c)
      pmbcs_pkg::CMD_STORE: cmd_len = 2'h0;
      pmbcs_pkg::CMD_OPER, pmbcs_pkg::CMD_ONOFF, pmbcs_pkg::CMD_WP: cmd_len = 2'h1;
      pmbcs_pkg::CMD_VOUT, pmbcs_pkg::CMD_MHI, pmbcs_pkg::CMD_MLO, pmbcs_pkg::CMD_VINON,
      pmbcs_pkg::CMD_VINOF, pmbcs_pkg::CMD_TDLY, pmbcs_pkg::CMD_TRISE, pmbcs_pkg::CMD_RVIN,
      pmbcs_pkg::CMD_RVOUT, pmbcs_pkg::CMD_RIOUT, pmbcs_pkg::CMD_VOTRM, pmbcs_pkg::CMD_VITRM,
      pmbcs_pkg::CMD_VIGN: cmd_len = 2'h2;
      default: cmd_len = 2'h3;
    endcase
  endfunction

  // linear word check: exponent fixed, positive mantissa in range
  function automatic logic lin_ok(input logic [15:0] w, input logic [4:0] e,
                                  input logic [10:0] lo, input logic [10:0] hi);
    lin_ok = (w[15:11] == e) && (w[10:0] >= lo) && (w[10:0] <= hi);
  endfunction

  logic [15:0] rd_vout; // corrected output reading
  logic [26:0] vin_prod; // raw input times gain
  logic [15:0] rd_vin; // corrected input reading
  logic [15:0] rd_iout; // blanked current reading

  // readbacks from raw samples and trims
  always_comb begin
    rd_vout = vout_adc_i + pmbcs_pkg::VOTRM_RST;
    vin_prod = vin_adc_i * pmbcs_pkg::VIGN_RST;
    rd_vin = {pmbcs_pkg::EXP_M3, 11'(vin_prod[23:13] + pmbcs_pkg::VITRM_RST[10:0])};
    if (iout_adc_i[10] || iout_adc_i < pmbcs_pkg::IOUT_BLANK) begin
      rd_iout = {pmbcs_pkg::EXP_M3, 11'h000};
    end else begin
      rd_iout = {pmbcs_pkg::EXP_M3, iout_adc_i};
    end
  end

  logic [15:0] rval; // value a read returns

  // read mux by command
  always_comb begin
    case (s_r.cmd)
      pmbcs_pkg::CMD_OPER: rval = {8'h00, s_r.op};
      pmbcs_pkg::CMD_ONOFF: rval = {8'h00, s_r.cfg};
      pmbcs_pkg::CMD_WP: rval = {15'h0000, s_r.wp};
      pmbcs_pkg::CMD_VOUT: rval = s_r.vout;
      pmbcs_pkg::CMD_MHI: rval = s_r.mhi;
      pmbcs_pkg::CMD_MLO: rval = s_r.mlo;
      pmbcs_pkg::CMD_VINON: rval = s_r.vin_on;
      pmbcs_pkg::CMD_VINOF: rval = s_r.vin_off;
      pmbcs_pkg::CMD_TDLY: rval = s_r.tdly;
      pmbcs_pkg::CMD_TRISE: rval = s_r.trise;
      pmbcs_pkg::CMD_RVIN: rval = rd_vin;
      pmbcs_pkg::CMD_RVOUT: rval = rd_vout;
      pmbcs_pkg::CMD_RIOUT: rval = rd_iout;
      pmbcs_pkg::CMD_VOTRM: rval = pmbcs_pkg::VOTRM_RST;
      pmbcs_pkg::CMD_VITRM: rval = pmbcs_pkg::VITRM_RST;
      pmbcs_pkg::CMD_VIGN: rval = pmbcs_pkg::VIGN_RST;
      default: rval = 16'hffff; // unsupported codes: all ones, never sent; a read of them repeats the check byte
    endcase
  end

  logic rise, fall, start, stop; // bus events
  logic commit; // a write ends well-formed
  logic [15:0] wword; // written word
  logic [1:0] wlen; // bytes the written command carries
  logic [7:0] txb; // next byte to send
  logic txpec; // next byte is the error check

  // bus events and commit qualifier
  always_comb begin
    rise = s_r.scl2 & ~s_r.scl3;
    fall = ~s_r.scl2 & s_r.scl3;
    start = s_r.scl2 & s_r.scl3 & s_r.sda3 & ~s_r.sda2;
    stop = s_r.scl2 & s_r.scl3 & ~s_r.sda3 & s_r.sda2;
    wlen = cmd_len(s_r.cmd);
    wword = {s_r.d1, s_r.d0};
    // error byte optional; when given, the whole check must come out zero
    commit = stop && !s_r.rd && (s_r.st != pmbcs_pkg::S_IDLE) && (wlen != 2'h3) &&
             ((s_r.nb == 3'(wlen) + 3'h1) ||
              ((s_r.nb == 3'(wlen) + 3'h2) && (s_r.crc == 8'h00)));
    txpec = (s_r.txi >= cmd_len(s_r.cmd)) || (cmd_len(s_r.cmd) == 2'h3);
    txb = txpec ? s_r.crc : (s_r.txi == 2'h0 ? rval[7:0] : rval[15:8]);
  end

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // two-flop synchronisers, plus one history stage on clock and data
    s_nxt.scl1 = scl_i;
    s_nxt.scl2 = s_r.scl1;
    s_nxt.scl3 = s_r.scl2;
    s_nxt.sda1 = sda_i;
    s_nxt.sda2 = s_r.sda1;
    s_nxt.sda3 = s_r.sda2;
    s_nxt.pin1 = on_off_pin_i;
    s_nxt.pin2 = s_r.pin1;
    s_nxt.store = 1'b0;
    if (start) begin
      // fresh transfer clears the check; a repeated start keeps it running
      if (s_r.st == pmbcs_pkg::S_IDLE) begin
        s_nxt.crc = 8'h00;
        s_nxt.nb = 3'h0;
      end
      s_nxt.st = pmbcs_pkg::S_RX;
      s_nxt.adr = 1'b1;
      s_nxt.bcnt = 4'h0;
      s_nxt.txi = 2'h0;
      s_nxt.oe = 1'b0;
    end else if (stop) begin
      s_nxt.st = pmbcs_pkg::S_IDLE;
      s_nxt.oe = 1'b0;
      if (commit) begin
        case (s_r.cmd)
          pmbcs_pkg::CMD_STORE: s_nxt.store = 1'b1;
          pmbcs_pkg::CMD_WP: s_nxt.wp = s_r.d0[0];
          pmbcs_pkg::CMD_OPER: begin
            // bits 6, 3..0 read only: margin field keeps the fault-acting form
            s_nxt.op = {s_r.d0[7], 1'b0, s_r.d0[5:4], 4'h8};
          end
          pmbcs_pkg::CMD_ONOFF: begin
            if (!s_r.wp) begin
              s_nxt.cfg[pmbcs_pkg::CFG_CMD] = s_r.d0[pmbcs_pkg::CFG_CMD];
            end
          end
          pmbcs_pkg::CMD_VINON: begin
            if (!s_r.wp && lin_ok(wword, pmbcs_pkg::EXP_M3, pmbcs_pkg::VIN_MIN, pmbcs_pkg::VIN_MAX)) begin
              s_nxt.vin_on = wword;
            end
          end
          pmbcs_pkg::CMD_VINOF: begin
            if (!s_r.wp && lin_ok(wword, pmbcs_pkg::EXP_M3, pmbcs_pkg::VIN_MIN, pmbcs_pkg::VIN_MAX)) begin
              s_nxt.vin_off = wword;
            end
          end
          pmbcs_pkg::CMD_TDLY: begin
            if (!s_r.wp && lin_ok(wword, pmbcs_pkg::EXP_M1, pmbcs_pkg::TDLY_MIN, pmbcs_pkg::TON_MAX)) begin
              s_nxt.tdly = wword;
            end
          end
          pmbcs_pkg::CMD_TRISE: begin
            if (!s_r.wp && lin_ok(wword, pmbcs_pkg::EXP_M1, pmbcs_pkg::TRISE_MIN, pmbcs_pkg::TON_MAX)) begin
              s_nxt.trise = wword;
            end
          end
          pmbcs_pkg::CMD_VOUT: begin
            if (!s_r.wp && wword >= pmbcs_pkg::VOUT_MIN && wword <= pmbcs_pkg::VOUT_MAX) begin
              s_nxt.vout = wword;
            end
          end
          pmbcs_pkg::CMD_MHI: begin
            if (!s_r.wp) begin
              s_nxt.mhi = wword;
            end
          end
          pmbcs_pkg::CMD_MLO: begin
            if (!s_r.wp) begin
              s_nxt.mlo = wword;
            end
          end
          default: s_nxt.store = 1'b0; // read-only codes ignore writes
        endcase
      end
    end else begin
      case (s_r.st)
        pmbcs_pkg::S_RX: begin
          if (rise && s_r.bcnt < 4'h8) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda2};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
          end else if (fall && s_r.bcnt == 4'h8) begin
            s_nxt.crc = crc8(s_r.crc, s_r.sh);
            s_nxt.bcnt = 4'h0;
            if (s_r.adr) begin
              s_nxt.adr = 1'b0;
              if (s_r.sh[7:1] == BUS_ADDR) begin
                s_nxt.rd = s_r.sh[0];
                s_nxt.oe = 1'b1;
                s_nxt.st = pmbcs_pkg::S_RXACK;
              end else begin
                s_nxt.st = pmbcs_pkg::S_IDLE; // not ours
              end
            end else begin
              // command, low byte, high byte, then error byte
              case (s_r.nb)
                3'h0: s_nxt.cmd = s_r.sh;
                3'h1: s_nxt.d0 = s_r.sh;
                3'h2: s_nxt.d1 = s_r.sh;
                default: s_nxt.d1 = s_r.d1;
              endcase
              if (s_r.nb != 3'h7) begin
                s_nxt.nb = s_r.nb + 3'h1;
              end
              s_nxt.oe = 1'b1;
              s_nxt.st = pmbcs_pkg::S_RXACK;
            end
          end
        end
        pmbcs_pkg::S_RXACK: begin
          if (fall) begin
            if (s_r.rd) begin
              // load the next reply byte and present its msb
              s_nxt.sh = txb;
              s_nxt.oe = ~txb[7];
              s_nxt.bcnt = 4'h0;
              s_nxt.st = pmbcs_pkg::S_TX;
              if (!txpec) begin
                s_nxt.crc = crc8(s_r.crc, txb);
              end
              if (s_r.txi != 2'h3) begin
                s_nxt.txi = s_r.txi + 2'h1;
              end
            end else begin
              s_nxt.oe = 1'b0;
              s_nxt.st = pmbcs_pkg::S_RX;
            end
          end
        end
        pmbcs_pkg::S_TX: begin
          if (fall) begin
            if (s_r.bcnt == 4'h7) begin
              s_nxt.oe = 1'b0; // release for the host ack
              s_nxt.st = pmbcs_pkg::S_TXACK;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.oe = ~s_r.sh[6];
              s_nxt.bcnt = s_r.bcnt + 4'h1;
            end
          end
        end
        pmbcs_pkg::S_TXACK: begin
          if (rise) begin
            // a not-ack ends the reply; an ack asks for one more
            s_nxt.st = s_r.sda2 ? pmbcs_pkg::S_IDLE : pmbcs_pkg::S_RXACK;
          end
        end
        default: s_nxt.st = pmbcs_pkg::S_IDLE;
      endcase
    end
    // start-up gating: pin always required, on bit only when obeyed
    s_nxt.out_en = s_r.pin2 && (!s_r.cfg[pmbcs_pkg::CFG_CMD] || s_r.op[pmbcs_pkg::OP_ON]);
    // margin select on bits 5:2
    case (s_r.op[5:2])
      4'b0110: s_nxt.vtgt = s_r.mlo;
      4'b1010: s_nxt.vtgt = s_r.mhi;
      default: s_nxt.vtgt = s_r.vout;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.scl1 <= 1'b1;
      s_r.scl2 <= 1'b1;
      s_r.scl3 <= 1'b1;
      s_r.sda1 <= 1'b1;
      s_r.sda2 <= 1'b1;
      s_r.sda3 <= 1'b1;
      s_r.st <= pmbcs_pkg::S_IDLE;
      s_r.wp <= 1'b1;
      s_r.op <= pmbcs_pkg::OP_RST;
      s_r.cfg <= pmbcs_pkg::CFG_RST;
      s_r.vin_on <= pmbcs_pkg::VINON_RST;
      s_r.vin_off <= pmbcs_pkg::VINOF_RST;
      s_r.tdly <= pmbcs_pkg::TDLY_RST;
      s_r.trise <= pmbcs_pkg::TRISE_RST;
      s_r.vout <= pmbcs_pkg::VOUT_RST;
      s_r.mhi <= pmbcs_pkg::MHI_RST;
      s_r.mlo <= pmbcs_pkg::MLO_RST;
      s_r.vtgt <= pmbcs_pkg::VOUT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state; data drive value tied low
  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o = s_r.oe;
  assign out_en_o = s_r.out_en;
  assign vout_target_o = s_r.vtgt;
  assign turn_on_delay_time_o = s_r.tdly;
  assign turn_on_rise_time_o = s_r.trise;
  assign vin_on_o = s_r.vin_on;
  assign vin_off_o = s_r.vin_off;
  assign store_o = s_r.store;

  // checks
  property p_wp_clear;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.wp && !s_nxt.wp |-> commit && s_r.cmd == pmbcs_pkg::CMD_WP;
  endproperty
  a_wp_clear: assert property (p_wp_clear) else $error("protection dropped without command");
  property p_wp_hold;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.wp && commit && s_r.cmd == pmbcs_pkg::CMD_VOUT |=> $stable(s_r.vout);
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("protected set-point changed");
  property p_store;
    @(posedge clk_i) disable iff (!rst_b_i)
      commit && s_r.cmd == pmbcs_pkg::CMD_STORE |=> store_o ##1 !store_o;
  endproperty
  a_store: assert property (p_store) else $error("store strobe missing");
  property p_pin;
    @(posedge clk_i) disable iff (!rst_b_i) !s_r.pin2 |=> !out_en_o;
  endproperty
  a_pin: assert property (p_pin) else $error("enabled without pin");
  property p_cmd_bit;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.pin2 && !s_r.cfg[pmbcs_pkg::CFG_CMD] |=> out_en_o;
  endproperty
  a_cmd_bit: assert property (p_cmd_bit) else $error("on bit not ignored");
  property p_off;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.cfg[pmbcs_pkg::CFG_CMD] && !s_r.op[pmbcs_pkg::OP_ON] |=> !out_en_o;
  endproperty
  a_off: assert property (p_off) else $error("enabled while commanded off");
  property p_margin;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.op[5:2] == 4'b0110 && $stable(s_r.op) |=> vout_target_o == $past(s_r.mlo);
  endproperty
  a_margin: assert property (p_margin) else $error("margin low not applied");
  property p_vin_rng;
    @(posedge clk_i) disable iff (!rst_b_i)
      vin_on_o[10:0] >= pmbcs_pkg::VIN_MIN && vin_on_o[10:0] <= pmbcs_pkg::VIN_MAX;
  endproperty
  a_vin_rng: assert property (p_vin_rng) else $error("threshold out of range");
  property p_vout_rng;
    @(posedge clk_i) disable iff (!rst_b_i)
      s_r.vout >= pmbcs_pkg::VOUT_MIN && s_r.vout <= pmbcs_pkg::VOUT_MAX;
  endproperty
  a_vout_rng: assert property (p_vout_rng) else $error("set-point out of range");
  property p_cfg;
    @(posedge clk_i) disable iff (!rst_b_i) s_r.cfg[7:4] == 4'h1 && s_r.cfg[2:0] == 3'h7;
  endproperty
  a_cfg: assert property (p_cfg) else $error("read-only option bits moved");
  property p_blank;
    @(posedge clk_i) disable iff (!rst_b_i)
      iout_adc_i < pmbcs_pkg::IOUT_BLANK |-> rd_iout[10:0] == 11'h000;
  endproperty
  a_blank: assert property (p_blank) else $error("current not blanked");
  c_store: cover property (@(posedge clk_i) disable iff (!rst_b_i) store_o);
  c_read: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    s_r.st == pmbcs_pkg::S_TX && s_r.txi == 2'h3);
  c_wp_off: cover property (@(posedge clk_i) disable iff (!rst_b_i) !s_r.wp);
endmodule
`default_nettype wire

/* pmbcs_host.sv */
`timescale 1ns/100ps
`default_nettype none
// bus host model: bit-banged master with a settable quarter-bit time
module pmbcs_host (
  input wire logic clk_i, // system clock
  input wire logic sda_i, // resolved data level
  output logic scl_o, // bus clock, idles high
  output logic sda_oe_o, // host pulls data low
  output logic [15:0] rd_o, // last word read
  output logic pec_ok_o, // appended check byte matched
  output logic rd_stb_o // one-clock read result strobe
);
  int q = 10; // quarter bit in clocks
  logic [7:0] crc; // running check byte, poly 07
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_stb_o = 1'b0;
  end
  // pins change just after a clock edge only
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one quarter-bit step of both pins; d=1 releases data
  task automatic step(input logic s, input logic d);
    scl_o = s;
    sda_oe_o = !d;
    wt(q);
  endtask
  // one bit slot; data held through the whole high phase
  task automatic xbit(input logic v, output logic s);
    step(1'b0, v);
    step(1'b1, v);
    s = sda_i;
    step(1'b1, v);
    step(1'b0, v);
  endtask
  // eight bits msb first plus ack slot; folds bus bits into the check byte
  task automatic xbyte(input logic [7:0] v, input logic last, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xbit(v[i], r[i]);
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ r[i]) ? 8'h07 : 8'h00);
    end
    xbit(last, a);
  endtask
  task automatic start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // write of n data bytes, low first; pm 0 none, 1 good check, 2 bad check
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d, input int pm);
    logic [7:0] r;
    start();
    crc = 8'h00;
    xbyte(8'h20, 1'b1, r);
    xbyte(c, 1'b1, r);
    for (int i = 0; i < n; i++) xbyte(d[8*i+:8], 1'b1, r);
    if (pm > 0) xbyte(crc ^ {7'h00, pm == 2}, 1'b1, r);
    stop();
  endtask
  // word read with repeated start; last byte nacked
  task automatic rd(input logic [7:0] c);
    logic [7:0] lo, hi, p, e;
    start();
    crc = 8'h00;
    xbyte(8'h20, 1'b1, lo);
    xbyte(c, 1'b1, lo);
    start();
    xbyte(8'h21, 1'b1, lo);
    xbyte(8'hff, 1'b0, lo);
    xbyte(8'hff, 1'b0, hi);
    e = crc;
    xbyte(8'hff, 1'b1, p);
    stop();
    rd_o = {hi, lo};
    pec_ok_o = (p === e);
    rd_stb_o = 1'b1;
    wt(1);
    rd_stb_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* power_module_pmbus_command_set_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// self-checking bench: host model on the bus, adc inputs driven directly
module power_module_pmbus_command_set_tb;
  logic clk_i = 1'b0; // 250 MHz clock
  logic rst_b_i = 1'b0; // reset, active low
  logic scl, h_oe, d_oe, d_val, pin, store, out_en, rd_stb, pec_ok; // bus and control
  logic [15:0] vo_adc, tgt, dly, rise, von, voff, rd; // words
  logic [10:0] vi_adc, io_adc; // raw mantissas
  logic [15:0] exp_q[$]; // expected read words, oldest first
  logic [7:0] ops[3] = '{8'h98, 8'ha8, 8'h84}; // margin low, high, off
  logic [15:0] tg[3] = '{pmbcs_pkg::MLO_RST, 16'hd000, 16'h819a}; // targets
  int err_count = 0;
  int cmp_count = 0;
  int n_store = 0; // store strobes seen
  wire sda = !h_oe && (!d_oe || d_val); // pulled-up wire, device drives its data value
  always #2 clk_i = !clk_i;
  pmbcs_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(d_val),
    .sda_oe_o(d_oe), .on_off_pin_i(pin), .vout_adc_i(vo_adc), .vin_adc_i(vi_adc),
    .iout_adc_i(io_adc), .out_en_o(out_en), .vout_target_o(tgt), .turn_on_delay_time_o(dly),
    .turn_on_rise_time_o(rise), .vin_on_o(von), .vin_off_o(voff), .store_o(store));
  pmbcs_host host_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe), .rd_o(rd),
    .pec_ok_o(pec_ok), .rd_stb_o(rd_stb));
  task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrc(input logic [7:0] c, input int n, input logic [15:0] d, input int pm);
    host_u.wr(c, n, d, pm);
    host_u.wt(4);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.rd(c);
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // monitor: each read result takes the oldest expected word
  always @(posedge clk_i) begin
    if (rd_stb === 1'b1) begin
      cmp_w(rd, exp_q.pop_front());
      cmp_b(pec_ok, 1'b1);
    end
    if (store === 1'b1) n_store++;
  end
  // watchdog
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'he4f11e24));
    {pin, vo_adc, vi_adc, io_adc} = '0;
    repeat (3) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    host_u.wt(4);
    cmp_w(tgt, pmbcs_pkg::VOUT_RST);
    cmp_w(dly, pmbcs_pkg::TDLY_RST);
    cmp_b(out_en, 1'b0);
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'ha000, 1);
    cmp_w(tgt, pmbcs_pkg::VOUT_RST);
    endt("protect");
    host_u.q = 156;
    wrc(pmbcs_pkg::CMD_WP, 1, 16'h0000, 0);
    host_u.q = 10;
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'ha000, 1);
    cmp_w(tgt, 16'ha000);
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'hd334, 0);
    cmp_w(tgt, 16'ha000);
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'h819a, 2);
    cmp_w(tgt, 16'ha000);
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'h819a, 0);
    cmp_w(tgt, 16'h819a);
    wrc(pmbcs_pkg::CMD_VINON, 2, 16'he920, 1);
    wrc(pmbcs_pkg::CMD_VINOF, 2, 16'he910, 0);
    cmp_w(von, 16'he920);
    cmp_w(voff, 16'he910);
    wrc(pmbcs_pkg::CMD_VINON, 2, 16'hf120, 0);
    cmp_w(von, 16'he920);
    wrc(pmbcs_pkg::CMD_VINON, 2, 16'he971, 0);
    cmp_w(von, 16'he920);
    wrc(pmbcs_pkg::CMD_TDLY, 2, 16'hfbe8, 0);
    cmp_w(dly, 16'hfbe8);
    wrc(pmbcs_pkg::CMD_TDLY, 2, 16'hf813, 0);
    cmp_w(dly, 16'hfbe8);
    wrc(pmbcs_pkg::CMD_TRISE, 2, 16'hf81d, 0);
    cmp_w(rise, pmbcs_pkg::TRISE_RST);
    endt("words");
    pin = 1'b1;
    wrc(pmbcs_pkg::CMD_OPER, 1, 16'h0000, 0);
    cmp_b(out_en, 1'b0);
    wrc(pmbcs_pkg::CMD_OPER, 1, 16'h0080, 0);
    cmp_b(out_en, 1'b1);
    pin = 1'b0;
    host_u.wt(8);
    cmp_b(out_en, 1'b0);
    pin = 1'b1;
    wrc(pmbcs_pkg::CMD_ONOFF, 1, 16'h0017, 0);
    wrc(pmbcs_pkg::CMD_OPER, 1, 16'h0000, 0);
    cmp_b(out_en, 1'b1);
    wrc(pmbcs_pkg::CMD_ONOFF, 1, 16'h001f, 0);
    cmp_b(out_en, 1'b0);
    wrc(pmbcs_pkg::CMD_MHI, 2, 16'hd000, 0);
    for (int i = 0; i < 3; i++) begin
      wrc(pmbcs_pkg::CMD_OPER, 1, {8'h00, ops[i]}, 0);
      cmp_w(tgt, tg[i]);
    end
    endt("onoff");
    vo_adc = 16'($urandom());
    vi_adc = 11'($urandom_range(1023));
    rdc(pmbcs_pkg::CMD_RVOUT, vo_adc + pmbcs_pkg::VOTRM_RST);
    rdc(pmbcs_pkg::CMD_RVIN, {pmbcs_pkg::EXP_M3, vi_adc});
    io_adc = 11'd13;
    rdc(pmbcs_pkg::CMD_RIOUT, {pmbcs_pkg::EXP_M3, 11'h000});
    io_adc = 11'd14;
    rdc(pmbcs_pkg::CMD_RIOUT, {pmbcs_pkg::EXP_M3, 11'd14});
    io_adc = 11'($urandom_range(1000, 15));
    rdc(pmbcs_pkg::CMD_RIOUT, {pmbcs_pkg::EXP_M3, io_adc});
    rdc(pmbcs_pkg::CMD_MHI, 16'hd000);
    endt("readback");
    wrc(pmbcs_pkg::CMD_STORE, 0, 16'h0000, 1);
    cmp_w(16'(n_store), 16'h0001);
    wrc(pmbcs_pkg::CMD_WP, 1, 16'h0001, 0);
    wrc(pmbcs_pkg::CMD_VOUT, 2, 16'hb000, 0);
    cmp_w(tgt, 16'h819a);
    endt("store");
    final_report();
  end
endmodule
`default_nettype wire
